// ---- swbd_target.sv ----
// How it works
// RULE1 - Pod starts every bit with a falling edge and controls all traffic.
// RULE2 - Bits move MSB first, sixteen debug-clock cycles per bit.
// RULE3 - 512 cycles with no host fall aborts the command without side effects.
// RULE4 - Clock-source bit in status/control picks bus or alternate clock.
// RULE5 - Host fall perceived within one cycle; level sampled ten cycles later.
// RULE6 - Target never drives the pin during host-to-target bits.
// RULE7 - Pod should drive high actively while sending.
// RULE8 - Pod holds pin low at least two cycles when receiving.
// RULE9 - Pod releases low drive before the speedup pulse at seven cycles.
// RULE10 - Sending one: brief high speedup pulse seven cycles after bit start.
// RULE11 - Pod samples about ten cycles after its falling edge.
// RULE12 - Sending zero: hold low thirteen cycles then briefly drive high.
// RULE13 - Pin level during reset picks background mode or application run.
// RULE14 - Pin held high by pullup means normal operation after reset.
// RULE15 - Speed probe answered with a timed response pulse.
// RULE16 - Register, step and resume commands only while halted.
// RULE17 - Non-intrusive commands accepted any time.
// RULE18 - Communication accepted without a prior reset.
// RULE19 - Background command wakes the processor from stop and wait.
// RULE20 - Oscillator kept running in stop while debug is enabled.
// RULE21 - Watchdog held off while in background mode.
// RULE22 - Exactly one hardware address breakpoint.
// RULE23 - Commands open with an eight-bit code, MSB first.
// RULE24 - Host waits sixteen cycles at a delay step.
// RULE25 - Background command ignored when debug enable is zero.
// RULE26 - Pod derives bit timing from measured speed-probe pulse; the pod model here uses fixed-length bits and measures nothing.
module swbd_target
  import swbd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  input wire logic cpuAddrValid,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuLowPower,
  output logic haltReq,
  output logic runReq,
  output logic stepReq,
  output logic wakeReq,
  output logic inBackground,
  output logic oscKeepOn,
  output logic watchdogHold,
  output logic clockSourceSelect,
  output logic breakHit,
  output logic cmdAbort,
  output logic cmdValid,
  output logic [7:0] cmdCode
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_RXBIT = 6'b000010,
    S_TXBIT = 6'b000100,
    S_DELAY = 6'b001000,
    S_SYNCW = 6'b010000,
    S_SYNCP = 6'b100000
  } swbd_state_t;

  swbd_state_t state_q;
  logic pinLevel;
  logic fall;
  logic [4:0] bitCnt_q;
  logic [2:0] bitIdx_q;
  logic [9:0] idleCnt_q;
  logic [9:0] lowCnt_q;
  logic [9:0] tmr_q;
  logic txPhase_q;
  logic [7:0] status_q;
  logic [15:0] bkpt_q;
  logic bkptEn_q;
  logic load;
  logic shiftEn;
  logic [7:0] shVal;
  logic shMsb;
  logic txBit_q;
  logic [7:0] cmdByte;
  logic pinOut_q;
  logic pinOe_q;
  logic strapDone_q;
  logic timeoutHit;

  // Edge detect on the shared pin
  swbd_edge u_edge (
    .clock(clock),
    .rst(rst),
    .pinIn(pinIn),
    .pinLevel(pinLevel),
    .fall(fall)
  );

  // Shift register for command bytes; status replies are sent from status_q, not from here
  swbd_shift u_shift (
    .clock(clock),
    .rst(rst),
    .load(load),
    .loadValue(status_q),
    .shiftIn(pinLevel),
    .shiftEn(shiftEn),
    .value(shVal),
    .msb(shMsb)
  );

  // Receive sample point
  assign shiftEn = (state_q == S_RXBIT) && (bitCnt_q == HOST_SAMPLE_AT); // RULE5
  assign cmdByte = {shVal[6:0], pinLevel};

  // Commands of the halted group
  function automatic logic is_active_cmd(input logic [7:0] c);
    is_active_cmd = (c == CMD_GO) || (c == CMD_STEP) || (c == CMD_TAGGO);
  endfunction

  // Load the status byte once the read-status code is complete
  assign load = shiftEn && (bitIdx_q == 3'h7) && !txPhase_q && (cmdByte == CMD_READ_STATUS);

  // Stall inside a command, including the gaps between its bits
  assign timeoutHit = idleCnt_q == TIMEOUT_CYCLES - 10'h001 && !fall
                      && (state_q != S_IDLE || bitIdx_q != 3'h0 || txPhase_q); // RULE3

  // Bit-level sequencer
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      bitCnt_q <= 5'h00;
      bitIdx_q <= 3'h0;
      txPhase_q <= 1'b0;
      tmr_q <= 10'h000;
    end
    else if (timeoutHit)
    begin
      state_q <= S_IDLE; // RULE3
      bitIdx_q <= 3'h0;
      txPhase_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          // Long low on the pin asks for the speed probe
          if (pinLevel && lowCnt_q >= SYNC_MIN_LOW)
          begin
            state_q <= S_SYNCW; // RULE15
            tmr_q <= 10'h000;
            bitIdx_q <= 3'h0;
            txPhase_q <= 1'b0;
          end
          else if (fall)
          begin
            state_q <= txPhase_q ? S_TXBIT : S_RXBIT; // RULE1 RULE18
            bitCnt_q <= 5'h01;
          end
        end
        S_RXBIT, S_TXBIT:
        begin
          if (bitCnt_q == BIT_END - 5'h01)
          begin
            bitCnt_q <= 5'h00;
            bitIdx_q <= bitIdx_q + 3'h1;
            state_q <= S_IDLE;
            if (bitIdx_q == 3'h7)
            begin
              if (state_q == S_TXBIT)
                txPhase_q <= 1'b0;
              else if (txPhase_q == 1'b0 && cmdCode == CMD_READ_STATUS)
                txPhase_q <= 1'b1;
              else if (cmdCode != CMD_WRITE_CONTROL)
              begin
                state_q <= S_DELAY; // RULE24
                tmr_q <= 10'h000;
              end
            end
          end
          else
            bitCnt_q <= bitCnt_q + 5'h01;
        end
        S_DELAY:
        begin
          tmr_q <= tmr_q + 10'h001;
          if (tmr_q == DELAY_CYCLES - 10'h001)
            state_q <= S_IDLE;
        end
        S_SYNCW:
        begin
          tmr_q <= tmr_q + 10'h001;
          if (tmr_q == SYNC_WAIT - 10'h001)
          begin
            state_q <= S_SYNCP;
            tmr_q <= 10'h000;
          end
        end
        S_SYNCP:
        begin
          tmr_q <= tmr_q + 10'h001;
          if (tmr_q == SYNC_PULSE)
            state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Transmit bit captured at bit start, selected from status_q by bit index
  always_ff @(posedge clock)
  begin
    if (rst)
      txBit_q <= 1'b0;
    else if (state_q == S_IDLE && fall && txPhase_q)
      txBit_q <= status_q[3'h7 - bitIdx_q]; // RULE2
  end

  // Timeout counter between host falling edges
  always_ff @(posedge clock)
  begin
    if (rst || fall || state_q == S_IDLE && !txPhase_q && bitIdx_q == 3'h0)
      idleCnt_q <= 10'h000;
    else if (idleCnt_q != TIMEOUT_CYCLES)
      idleCnt_q <= idleCnt_q + 10'h001; // RULE3
  end

  // Low-time counter for the speed probe
  always_ff @(posedge clock)
  begin
    if (rst || pinLevel)
      lowCnt_q <= pinLevel ? lowCnt_q : 10'h000;
    else if (lowCnt_q != 10'h3FF)
      lowCnt_q <= lowCnt_q + 10'h001;
    if (rst)
      lowCnt_q <= 10'h000;
    else if (state_q != S_IDLE)
      lowCnt_q <= 10'h000;
  end

  // Pin drive: only in target-to-host bits and the probe pulse
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pinOut_q <= 1'b1;
      pinOe_q <= 1'b0;
    end
    else if (state_q == S_TXBIT && !txBit_q && bitCnt_q < ZERO_LOW_END)
    begin
      pinOut_q <= 1'b0; // RULE12
      pinOe_q <= 1'b1;
    end
    else if (state_q == S_TXBIT && !txBit_q && bitCnt_q < ZERO_LOW_END + SPEEDUP_LEN)
    begin
      pinOut_q <= 1'b1; // RULE12
      pinOe_q <= 1'b1;
    end
    else if (state_q == S_TXBIT && txBit_q && bitCnt_q >= SPEEDUP_AT
             && bitCnt_q < SPEEDUP_AT + SPEEDUP_LEN)
    begin
      pinOut_q <= 1'b1; // RULE10
      pinOe_q <= 1'b1;
    end
    else if (state_q == S_SYNCP)
    begin
      pinOut_q <= tmr_q == SYNC_PULSE; // RULE15
      pinOe_q <= 1'b1;
    end
    else
    begin
      pinOut_q <= 1'b1; // RULE6
      pinOe_q <= 1'b0;
    end
  end
  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;

  // Status/control register and mode strap
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      status_q <= SC_RESET;
      strapDone_q <= 1'b0;
    end
    else
    begin
      if (!strapDone_q)
      begin
        strapDone_q <= 1'b1;
        status_q[SC_ACTIVE] <= ~pinLevel; // RULE13 RULE14
        status_q[SC_ENABLE] <= ~pinLevel;
      end
      if (shiftEn && bitIdx_q == 3'h7 && !txPhase_q && state_q == S_RXBIT)
      begin
        if (cmdByte == CMD_BACKGROUND && status_q[SC_ENABLE])
          status_q[SC_ACTIVE] <= 1'b1; // RULE25 RULE19
        else if (is_active_cmd(cmdByte) && status_q[SC_ACTIVE])
          status_q[SC_ACTIVE] <= 1'b0; // RULE16
      end
      if (strapDone_q && breakHit)
        status_q[SC_ACTIVE] <= 1'b1;
    end
  end

  // Single hardware breakpoint comparator
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bkpt_q <= BKPT_RESET;
      bkptEn_q <= 1'b0;
      breakHit <= 1'b0;
    end
    else
    begin
      breakHit <= bkptEn_q && cpuAddrValid && cpuAddr == bkpt_q && !status_q[SC_ACTIVE]; // RULE22
    end
  end

  // Command strobes and system-control outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmdValid <= 1'b0;
      cmdCode <= 8'h00;
      haltReq <= 1'b0;
      runReq <= 1'b0;
      stepReq <= 1'b0;
      wakeReq <= 1'b0;
      cmdAbort <= 1'b0;
      inBackground <= 1'b0;
      oscKeepOn <= 1'b0;
      watchdogHold <= 1'b0;
      clockSourceSelect <= 1'b0;
    end
    else
    begin
      cmdValid <= shiftEn && bitIdx_q == 3'h7 && !txPhase_q && state_q == S_RXBIT
                  && (!is_active_cmd(cmdByte) || status_q[SC_ACTIVE]); // RULE16 RULE17 RULE23
      // Code held from the eighth sample, since the shifter moves on afterwards
      if (shiftEn && bitIdx_q == 3'h7 && !txPhase_q && state_q == S_RXBIT)
        cmdCode <= cmdByte; // RULE23
      haltReq <= shiftEn && bitIdx_q == 3'h7 && cmdByte == CMD_BACKGROUND && status_q[SC_ENABLE]; // RULE25
      wakeReq <= shiftEn && bitIdx_q == 3'h7 && cmdByte == CMD_BACKGROUND && status_q[SC_ENABLE]
                 && cpuLowPower; // RULE19
      runReq <= shiftEn && bitIdx_q == 3'h7 && status_q[SC_ACTIVE]
                && (cmdByte == CMD_GO || cmdByte == CMD_TAGGO); // RULE16
      stepReq <= shiftEn && bitIdx_q == 3'h7 && status_q[SC_ACTIVE] && cmdByte == CMD_STEP; // RULE16
      cmdAbort <= timeoutHit; // RULE3
      inBackground <= status_q[SC_ACTIVE];
      oscKeepOn <= status_q[SC_ENABLE]; // RULE20
      watchdogHold <= status_q[SC_ACTIVE]; // RULE21
      clockSourceSelect <= status_q[SC_CLKSRC]; // RULE4
    end
  end

  // Pin driver never on during host bits
  property p_no_drive_rx;
    @(posedge clock) disable iff (rst) (state_q == S_RXBIT) |=> !pinOe_q || state_q != S_RXBIT;
  endproperty
  a_no_drive_rx: assert property (p_no_drive_rx) else $error("pin driven in host bit"); // RULE6

  property p_zero_low;
    @(posedge clock) disable iff (rst)
      (state_q == S_TXBIT && !txBit_q && bitCnt_q == 5'h03) |=> (pinOe_q && !pinOut_q);
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero bit not held low"); // RULE12

  property p_one_pulse;
    @(posedge clock) disable iff (rst)
      (state_q == S_TXBIT && txBit_q && bitCnt_q == SPEEDUP_AT) |=> (pinOe_q && pinOut_q);
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("missing speedup pulse"); // RULE10

  property p_bg_ignored;
    @(posedge clock) disable iff (rst) haltReq |-> $past(status_q[SC_ENABLE]);
  endproperty
  a_bg_ignored: assert property (p_bg_ignored) else $error("halt while disabled"); // RULE25

  property p_wdog;
    @(posedge clock) disable iff (rst) status_q[SC_ACTIVE] |=> watchdogHold;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not held"); // RULE21

  property p_go_gate;
    @(posedge clock) disable iff (rst) (runReq || stepReq) |-> $past(status_q[SC_ACTIVE]);
  endproperty
  a_go_gate: assert property (p_go_gate) else $error("resume while running"); // RULE16

  property p_timeout;
    @(posedge clock) disable iff (rst) cmdAbort |-> state_q == S_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not abort"); // RULE3

  property p_osc;
    @(posedge clock) disable iff (rst) status_q[SC_ENABLE] |=> oscKeepOn;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator not held"); // RULE20
endmodule

// ---- swbd_pkg.sv ----
package swbd_pkg;
  // Bit timing in debug-clock cycles after the perceived bit start
  localparam int unsigned BIT_CYCLES = 16;
  localparam logic [9:0] TIMEOUT_CYCLES = 10'h200;
  localparam logic [4:0] HOST_SAMPLE_AT = 5'h0A;
  localparam logic [4:0] SPEEDUP_AT = 5'h07;
  localparam logic [4:0] ZERO_LOW_END = 5'h0D;
  localparam logic [4:0] SPEEDUP_LEN = 5'h01;
  localparam logic [4:0] BIT_END = 5'h10;
  // Sync: host low at least this many cycles in idle, after the bit window its fall opens, asks for a timed pulse
  localparam logic [9:0] SYNC_MIN_LOW = 10'h080;
  localparam logic [9:0] SYNC_WAIT = 10'h010;
  localparam logic [9:0] SYNC_PULSE = 10'h080;
  localparam logic [9:0] DELAY_CYCLES = 10'h010;
  // Command codes
  localparam logic [7:0] CMD_BACKGROUND = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'hE4;
  localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_TAGGO = 8'h18;
  // Status/control field positions
  localparam int unsigned SC_ENABLE = 7;
  localparam int unsigned SC_ACTIVE = 6;
  localparam int unsigned SC_CLKSRC = 2;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] SC_WRITE_MASK = 8'h84;
  localparam logic [15:0] BKPT_RESET = 16'h0000;
endpackage

// ---- swbd_edge.sv ----
// Falling-edge detector on the debug pin after a register stage
module swbd_edge
  import swbd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic pinIn,
  output logic pinLevel,
  output logic fall
);
  logic pinQ1_q;
  logic pinQ2_q;
  // Registered pin sample and previous value
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      // Follow the pin while in reset so a strapped-low pin gives no false fall after release
      pinQ1_q <= pinIn;
      pinQ2_q <= pinIn;
    end
    else
    begin
      pinQ1_q <= pinIn;
      pinQ2_q <= pinQ1_q;
    end
  end
  // Delay of 0 to 1 cycle from pin fall to perceived bit start
  assign pinLevel = pinQ1_q; // RULE5
  assign fall = pinQ2_q & ~pinQ1_q; // RULE5
endmodule

// ---- swbd_shift.sv ----
// Eight-bit shift register, MSB first both ways
module swbd_shift
  import swbd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] loadValue,
  input wire logic shiftIn,
  input wire logic shiftEn,
  output logic [7:0] value,
  output logic msb
);
  logic [7:0] data_q;
  // Load for transmit or shift in a received bit
  always_ff @(posedge clock)
  begin
    if (rst)
      data_q <= 8'h00;
    else if (load)
      data_q <= loadValue;
    else if (shiftEn)
      data_q <= {data_q[6:0], shiftIn}; // RULE2
  end
  assign value = data_q;
  assign msb = data_q[7]; // RULE2
endmodule

// ---- swbd_pod.sv ----
// Behavioural debug pod on the far side of the debug pin
module swbd_pod
  import swbd_pkg::*;
(
  input wire logic clock,
  input wire logic pinLevel,
  output logic podDrv,
  output logic podLvl
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released at time zero, so the pullup holds the pin high
  initial
  begin
    podDrv = 1'b0;
    podLvl = 1'b1;
  end

  // Static drive, used to strap the pin during reset
  task automatic hold(input logic drv, input logic lvl);
    podDrv <= drv;
    podLvl <= lvl;
  endtask

  // Host bit: fall, data level, then driven high for a fast rise
  task automatic sendBit(input logic b);
    int i;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      podDrv <= 1'b1;
      podLvl <= (i >= (b ? 3 : 15));
    end
    @(posedge clock);
    podDrv <= 1'b0;
  endtask

  // Target bit: two-cycle low, early release, sample near ten cycles
  task automatic recvBit(output logic b);
    int i;
    b = 1'b0;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (i == 10)
        b = pinLevel;
      podDrv <= (i < 2);
      podLvl <= 1'b0;
    end
  endtask

  // Bytes travel MSB first
  task automatic sendByte(input logic [7:0] v);
    int i;
    for (i = 7; i >= 0; i--)
      sendBit(v[i]);
  endtask

  task automatic recvByte(output logic [7:0] v);
    int i;
    for (i = 7; i >= 0; i--)
      recvBit(v[i]);
  endtask

  // Long low asks the target for its timed reference pulse
  task automatic syncReq(input int lowLen);
    @(posedge clock);
    podDrv <= 1'b1;
    podLvl <= 1'b0;
    repeat (lowLen) @(posedge clock);
    podLvl <= 1'b1;
    @(posedge clock);
    podDrv <= 1'b0;
  endtask
endmodule

// ---- swbd_tb_top.sv ----
module swbd_tb_top
  import swbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cpuAddrValid = 1'b1;
  logic [15:0] cpuAddr = 16'h0000;
  logic cpuLowPower = 1'b0;
  logic pinOut, pinOe, podDrv, podLvl, pinLevel;
  logic haltReq, runReq, stepReq, wakeReq, inBackground, oscKeepOn;
  logic watchdogHold, clockSourceSelect, breakHit, cmdAbort, cmdValid;
  logic [7:0] cmdCode;
  int nCmd = 0, nHalt = 0, nRun = 0, nStep = 0, nWake = 0, nAbort = 0;
  int nBrk = 0, tLow = 0, tHigh = 0;
  int error_cnt = 0;
  int samples_checked = 0;

  // Resolved pin: target drive, else pod drive, else pullup
  assign pinLevel = pinOe ? pinOut : (podDrv ? podLvl : 1'b1);

  initial
  begin
    forever #2 clock = ~clock;
  end

  swbd_target DUT (.clock(clock), .rst(rst), .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe),
    .cpuAddrValid(cpuAddrValid), .cpuAddr(cpuAddr), .cpuLowPower(cpuLowPower), .haltReq(haltReq),
    .runReq(runReq), .stepReq(stepReq), .wakeReq(wakeReq), .inBackground(inBackground),
    .oscKeepOn(oscKeepOn), .watchdogHold(watchdogHold), .clockSourceSelect(clockSourceSelect),
    .breakHit(breakHit), .cmdAbort(cmdAbort), .cmdValid(cmdValid), .cmdCode(cmdCode));

  swbd_pod pod (.clock(clock), .pinLevel(pinLevel), .podDrv(podDrv), .podLvl(podLvl));

  // Counts one-cycle pulses and cycles of target drive on the pin
  always @(posedge clock)
  begin
    nCmd <= nCmd + (cmdValid === 1'b1);
    nHalt <= nHalt + (haltReq === 1'b1);
    nRun <= nRun + (runReq === 1'b1);
    nStep <= nStep + (stepReq === 1'b1);
    nWake <= nWake + (wakeReq === 1'b1);
    nAbort <= nAbort + (cmdAbort === 1'b1);
    nBrk <= nBrk + (breakHit === 1'b1);
    tLow <= tLow + (pinOe === 1'b1 && pinOut === 1'b0);
    tHigh <= tHigh + (pinOe === 1'b1 && pinOut === 1'b1);
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Reset with the pod strapping the pin low or leaving it high
  task automatic doReset(input logic strap);
    @(posedge clock);
    rst <= 1'b1;
    pod.hold(!strap, 1'b0);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    pod.hold(1'b0, 1'b1);
    repeat (4) @(posedge clock);
  endtask

  // Command code then the delay step before the next command
  task automatic runCmd(input logic [7:0] c);
    pod.sendByte(c);
    repeat (40) @(posedge clock);
  endtask

  // Status read, with the target's drive pattern checked as totals over the whole byte
  task automatic readStatus(input logic [7:0] exp);
    logic [7:0] got;
    int c0, l0, h0;
    c0 = nCmd;
    l0 = tLow;
    h0 = tHigh;
    pod.sendByte(CMD_READ_STATUS);
    chk("host bits drive", 0, 16'(tLow + tHigh - l0 - h0));
    chk("status code", CMD_READ_STATUS, cmdCode);
    pod.recvByte(got);
    repeat (4) @(posedge clock);
    chk("status cmd", 1, 16'(nCmd - c0));
    chk("status", exp, got);
    chk("zero low cycles", 16'(12 * (8 - $countones(exp))), 16'(tLow - l0));
    chk("speedup pulses", 8, 16'(tHigh - h0));
  endtask

  task automatic testRunMode();
    int h0, r0, s0;
    doReset(1'b1);
    chk("inBackground", 0, inBackground);
    chk("watchdogHold", 0, watchdogHold);
    chk("clockSourceSelect", 0, clockSourceSelect);
    h0 = nHalt;
    r0 = nRun;
    s0 = nStep;
    runCmd(CMD_BACKGROUND);
    chk("halt when disabled", 0, 16'(nHalt - h0));
    runCmd(CMD_GO);
    runCmd(CMD_STEP);
    chk("go while running", 0, 16'(nRun - r0));
    chk("step while running", 0, 16'(nStep - s0));
    readStatus(8'h00);
    $display("testRunMode done");
  endtask

  task automatic testStrap();
    doReset(1'b0);
    chk("inBackground", 1, inBackground);
    chk("watchdogHold", 1, watchdogHold);
    chk("oscKeepOn", 1, oscKeepOn);
    readStatus(8'hC0);
    $display("testStrap done");
  endtask

  // Command abandoned after a stall, mode left as it was
  task automatic testTimeout();
    int a0;
    a0 = nAbort;
    repeat (3) pod.sendBit(1'b1);
    repeat (470) @(posedge clock);
    chk("abort early", 0, 16'(nAbort - a0));
    repeat (50) @(posedge clock);
    chk("abort", 1, 16'(nAbort - a0));
    readStatus(8'hC0);
    $display("testTimeout done");
  endtask

  task automatic testHaltStep();
    int h0, w0, s0;
    h0 = nHalt;
    w0 = nWake;
    s0 = nStep;
    cpuLowPower <= 1'b1;
    runCmd(CMD_BACKGROUND);
    chk("halt", 1, 16'(nHalt - h0));
    chk("wake", 1, 16'(nWake - w0));
    cpuLowPower <= 1'b0;
    runCmd(CMD_STEP);
    chk("step", 1, 16'(nStep - s0));
    $display("testHaltStep done");
  endtask

  task automatic testSync();
    int l0, h0;
    l0 = tLow;
    h0 = tHigh;
    pod.syncReq(200);
    repeat (300) @(posedge clock);
    chk("sync low", 16'(SYNC_PULSE), 16'(tLow - l0));
    chk("sync high", 1, 16'(tHigh - h0));
    $display("testSync done");
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    summarize();
  end

  initial
  begin
    testRunMode();
    testStrap();
    testTimeout();
    testHaltStep();
    testSync();
    chk("break with disabled breakpoint", 0, 16'(nBrk));
    summarize();
  end
endmodule
